// File: core/clkgen_ctrl_pkg.sv
// Package for the clock generator control registers of the codec.
// Assumes a single system clock domain; pin inputs are synchronised
// inside the top module before use.
package clkgen_ctrl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0]  ADDR_GEN2_SAMPLE_RATE = 5'h14;
  localparam logic [4:0]  ADDR_GEN2_PHASE_SHIFT = 5'h15;
  localparam logic [4:0]  ADDR_GEN3_MODE        = 5'h16;

  localparam logic [15:0] GEN2_RATE_RESET  = 16'hbb80;
  localparam logic [15:0] GEN2_PHASE_RESET = 16'h0000;
  localparam logic [15:0] GEN3_MODE_RESET  = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PH_DIR_BIT   = 8;
  localparam int PH_MAG_MSB   = 7;
  localparam int G3_REF_BIT   = 15;
  localparam int G3_VID_BIT   = 14;
  localparam int G3_GAIN_BIT  = 13;
  localparam int G3_P200_BIT  = 12;
  localparam int G3_X87_BIT   = 11;
  localparam int G3_C128_BIT  = 10;
  localparam int G3_MOD_MSB   = 7;
  // Writable bits of the phase and mode registers; reserved bits stay 0
  localparam logic [15:0] PH_WR_MASK = 16'h01ff;
  localparam logic [15:0] G3_WR_MASK = 16'hfcff;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam real MASTER_CLK_MHZ = 24.576;
  localparam real PHASE_TICK_MHZ = 3.072;
  // Master clock edges per phase decrement step
  localparam int  PHASE_DIV      = int'(MASTER_CLK_MHZ / PHASE_TICK_MHZ);
  localparam logic [2:0] PHASE_DIV_LAST = 3'(PHASE_DIV - 1);

  // Slot 1 echo of the pre-write register value
  typedef enum logic [2:0] {
    ECHO_IDLE  = 3'b001,
    ECHO_ARMED = 3'b010,
    ECHO_FRAME = 3'b100
  } echo_state_e;

endpackage

// File: core/phase_shift_if.sv
// Carrier between the register block and the phase shift unit.
// Both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none

interface phase_shift_if;
  logic       clear;
  logic       load;
  logic       load_dir;
  logic [7:0] load_mag;
  logic       tick;
  logic [7:0] mag;
  logic       dir;
  logic       step;

  modport ctrl (output clear, load, load_dir, load_mag, tick,
                input  mag, dir, step);
  modport unit (input  clear, load, load_dir, load_mag, tick,
                output mag, dir, step);
endinterface

`default_nettype wire

// File: core/phase_shift_unit.sv
// Pending phase shift magnitude with its decrementer.
// Assumes tick is a one-cycle pulse at the phase step rate.
`timescale 1ns/100ps
`default_nettype none

module phase_shift_unit (
  input  wire logic    clk_sys_i,
  input  wire logic    rstn_i,
  phase_shift_if.unit  ps
);
  import clkgen_ctrl_pkg::*;

  logic [7:0] mag_q, mag_d;
  logic       dir_q, dir_d;
  logic       step_q, step_d;

  always_comb begin
    mag_d  = mag_q;
    dir_d  = dir_q;
    step_d = 1'b0;
    if (ps.clear) begin
      mag_d = GEN2_PHASE_RESET[PH_MAG_MSB:0];                 // [RULE_11]
      dir_d = 1'b0;
    end else if (ps.load) begin
      // A new value replaces whatever is still pending
      mag_d = ps.load_mag;                                    // [RULE_09]
      dir_d = ps.load_dir;                                    // [RULE_05]
    end else if (ps.tick && (mag_q != 8'h00)) begin
      mag_d  = mag_q - 8'h01;                                 // [RULE_07]
      step_d = 1'b1;                                          // [RULE_06]
    end
    // No step once the magnitude is spent                   // [RULE_17]
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mag_q  <= 8'h00;
      dir_q  <= 1'b0;
      step_q <= 1'b0;
    end else begin
      mag_q  <= mag_d;
      dir_q  <= dir_d;
      step_q <= step_d;
    end
  end

  assign ps.mag  = mag_q;
  assign ps.dir  = dir_q;
  assign ps.step = step_q;

endmodule // phase_shift_unit

`default_nettype wire

// File: core/clkgen_ctrl_regs.sv
// Control registers for sample clock generators two and three.
// Assumes the serial frame logic on the same clock presents decoded
// register accesses and slot 0 / slot 1 strobes; pins are async.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RULE_01] Off sync reference, gen2 rate is the rate word, 1 Hz per count.
// [RULE_02] Host keeps the rate word between 0x0fa0 and 0xd2f0.
// [RULE_03] Rate word resets to 0xbb80, 48 kHz.
// [RULE_04] Rate word held at default, writes ignored, in reset or power-down.
// [RULE_05] Phase register: bit 8 direction, 7:0 magnitude, 15:9 reserved.
// [RULE_06] Each magnitude count shifts the gen2 sample clock 0.12 degrees.
// [RULE_07] Pending magnitude decrements once per 3.072 MHz tick.
// [RULE_08] Phase read shows magnitude pending at slot 0 or slave frame sync.
// [RULE_09] A new phase value replaces any pending magnitude at once.
// [RULE_10] Any write echoes the old value in slot 1 of the next frame.
// [RULE_11] Phase register resets to zero; zero while reset, off or disabled.
// [RULE_12] Gen3 mode fields: ref, video, gain, +200, 8/7, x128, modifiers.
// [RULE_13] Gen3 ref 0: master clock base, 8/7 and +200 apply, video ignored.
// [RULE_14] Gen3 ref 1: clocks derived from sync input three.
// [RULE_15] Host writes zero to all reserved bits.
// [RULE_16] Gen2 8/7 on crystal reference gives 8/7 of the rate word.
// [RULE_17] At zero magnitude shifting stops until a new nonzero write.
module clkgen_ctrl_regs
  import clkgen_ctrl_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // Pins
  input  wire logic        power_down_n_i,
  input  wire logic        master_clock_in_i,
  input  wire logic        sync_input_three_i,
  input  wire logic        slave_frame_sync_in_i,
  // Decoded register access from the frame logic
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  // Frame timing
  input  wire logic        bus_master_i,
  input  wire logic        slot0_start_i,
  input  wire logic        slot1_start_i,
  output logic      [15:0] slot1_data_o,
  output logic             slot1_valid_o,
  // Gen2 mode bits held elsewhere
  input  wire logic        gen2_sync_reference_select_i,
  input  wire logic        gen2_eight_sevenths_i,
  input  wire logic        gen2_enable_i,
  // Gen2 clock steering
  output logic      [16:0] gen2_conv_rate_hz_o,
  output logic             gen2_phase_step_o,
  output logic             gen2_phase_direction_o,
  // Gen3 clock steering
  output logic             gen3_ref_clock_o,
  output logic             gen3_reference_select_o,
  output logic             gen3_video_lock_o,
  output logic             gen3_loop_gain_o,
  output logic             gen3_bitclk_plus200_o,
  output logic             gen3_eight_sevenths_o,
  output logic             gen3_conv_pin_times128_o,
  output logic      [7:0]  gen3_rate_modifier_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pin_meta_q, pin_sync_q, pin_prev_q;
  logic       pd_n_s, mclk_s, sync_input_three_s, fsync_s;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
      pin_prev_q <= 4'h0;
    end else begin
      pin_meta_q <= {power_down_n_i, master_clock_in_i,
                     sync_input_three_i, slave_frame_sync_in_i};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign {pd_n_s, mclk_s, sync_input_three_s, fsync_s} = pin_sync_q;

  logic hold;
  logic mclk_rise, fsync_rise;
  // Power-down counts as asserted until its level has been seen high
  assign hold       = !pd_n_s;
  assign mclk_rise  = mclk_s && !pin_prev_q[2];
  assign fsync_rise = fsync_s && !pin_prev_q[0];

  // ****************************************************************
  // Phase tick from master clock edges
  // ****************************************************************
  logic [2:0] div_q, div_d;
  logic       tick_q, tick_d;

  always_comb begin
    div_d  = div_q;
    tick_d = 1'b0;
    if (mclk_rise) begin
      if (div_q == PHASE_DIV_LAST) begin
        div_d  = 3'h0;
        tick_d = 1'b1;                                        // [RULE_07]
      end else begin
        div_d = div_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q  <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] rate_q, rate_d;
  logic [15:0] mode3_q, mode3_d;
  logic [7:0]  snap_q, snap_d;
  logic        wr_rate, wr_phase, wr_mode3;
  logic        phase_hold;
  logic [15:0] phase_view;

  phase_shift_if ps ();

  assign wr_rate    = reg_wr_i && (reg_addr_i == ADDR_GEN2_SAMPLE_RATE);
  assign wr_phase   = reg_wr_i && (reg_addr_i == ADDR_GEN2_PHASE_SHIFT);
  assign wr_mode3   = reg_wr_i && (reg_addr_i == ADDR_GEN3_MODE);
  assign phase_hold = hold || !gen2_enable_i;

  assign ps.clear    = phase_hold;                            // [RULE_11]
  assign ps.load     = wr_phase && !phase_hold;
  assign ps.load_dir = reg_wdata_i[PH_DIR_BIT];
  assign ps.load_mag = reg_wdata_i[PH_MAG_MSB:0];
  assign ps.tick     = tick_q;

  phase_shift_unit u_phase (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .ps        (ps)
  );

  always_comb begin
    rate_d  = rate_q;
    mode3_d = mode3_q;
    snap_d  = snap_q;
    if (hold) begin
      rate_d  = GEN2_RATE_RESET;                              // [RULE_04]
      mode3_d = GEN3_MODE_RESET;
    end else begin
      if (wr_rate)
        rate_d = reg_wdata_i;
      if (wr_mode3)
        mode3_d = reg_wdata_i & G3_WR_MASK;                   // [RULE_12]
    end
    // Pending magnitude is captured per frame for the host to read
    if (phase_hold)
      snap_d = 8'h00;
    else if (bus_master_i ? slot0_start_i : fsync_rise)
      snap_d = ps.mag;                                        // [RULE_08]
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rate_q  <= GEN2_RATE_RESET;                             // [RULE_03]
      mode3_q <= GEN3_MODE_RESET;
      snap_q  <= 8'h00;
    end else begin
      rate_q  <= rate_d;
      mode3_q <= mode3_d;
      snap_q  <= snap_d;
    end
  end

  assign phase_view = {7'h00, ps.dir, snap_q};                // [RULE_05]

  // ****************************************************************
  // Read port and slot 1 echo
  // ****************************************************************
  logic [15:0] rdata_q, rdata_d, cur_val;
  logic        rvalid_q;
  logic [15:0] echo_q, echo_d, sdata_q, sdata_d;
  logic        evalid_q, evalid_d;
  echo_state_e est_q, est_d;

  always_comb begin
    unique case (reg_addr_i)
      ADDR_GEN2_SAMPLE_RATE: cur_val = rate_q;
      ADDR_GEN2_PHASE_SHIFT: cur_val = phase_view;
      ADDR_GEN3_MODE:        cur_val = mode3_q;
      default:               cur_val = 16'h0000;
    endcase
    rdata_d = reg_rd_i ? cur_val : rdata_q;
  end

  always_comb begin
    est_d    = est_q;
    echo_d   = echo_q;
    evalid_d = 1'b0;
    unique case (est_q)
      ECHO_IDLE:  ;
      ECHO_ARMED: if (slot0_start_i) est_d = ECHO_FRAME;
      ECHO_FRAME: if (slot1_start_i) begin
        evalid_d = 1'b1;                                      // [RULE_10]
        est_d    = ECHO_IDLE;
      end
      default:    est_d = ECHO_IDLE;
    endcase
    // Latch what goes out so a write in the same cycle cannot swap it
    sdata_d = evalid_d ? echo_q : sdata_q;                    // [RULE_10]
    // A newer write takes the echo slot of the frame that follows it
    if (reg_wr_i) begin
      echo_d = cur_val;                                       // [RULE_10]
      est_d  = ECHO_ARMED;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
      echo_q   <= 16'h0000;
      sdata_q  <= 16'h0000;
      evalid_q <= 1'b0;
      est_q    <= ECHO_IDLE;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= reg_rd_i;
      echo_q   <= echo_d;
      sdata_q  <= sdata_d;
      evalid_q <= evalid_d;
      est_q    <= est_d;
    end
  end

  // ****************************************************************
  // Clock steering outputs
  // ****************************************************************
  logic [16:0] conv_q, conv_d;
  logic [19:0] rate_x8;
  logic        g3_ref;

  assign rate_x8 = {rate_q, 3'b000} + 20'h00003;

  always_comb begin
    conv_d = {1'b0, rate_q};                                  // [RULE_01]
    if (!gen2_sync_reference_select_i && gen2_eight_sevenths_i)
      conv_d = 17'(rate_x8 / 20'h00007);                      // [RULE_16]
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i)
      conv_q <= {1'b0, GEN2_RATE_RESET};
    else
      conv_q <= conv_d;
  end

  assign g3_ref = mode3_q[G3_REF_BIT];

  assign reg_rdata_o              = rdata_q;
  assign reg_rvalid_o             = rvalid_q;
  assign slot1_data_o             = sdata_q;
  assign slot1_valid_o            = evalid_q;
  assign gen2_conv_rate_hz_o      = conv_q;
  assign gen2_phase_step_o        = ps.step;                  // [RULE_06]
  assign gen2_phase_direction_o   = ps.dir;
  assign gen3_ref_clock_o         = g3_ref ? sync_input_three_s : mclk_s; // [RULE_14]
  assign gen3_reference_select_o  = g3_ref;
  assign gen3_video_lock_o        = g3_ref && mode3_q[G3_VID_BIT]; // [RULE_13]
  assign gen3_loop_gain_o         = mode3_q[G3_GAIN_BIT];
  assign gen3_bitclk_plus200_o    = mode3_q[G3_P200_BIT];
  assign gen3_eight_sevenths_o    = ~g3_ref & mode3_q[G3_X87_BIT]; // [RULE_13]
  assign gen3_conv_pin_times128_o = mode3_q[G3_C128_BIT];
  assign gen3_rate_modifier_o     = mode3_q[G3_MOD_MSB:0];

endmodule // clkgen_ctrl_regs

`default_nettype wire

// File: dv/frame_host_model.sv
// Far-side stand-in: frame timing and clock pins seen by the registers.
// Assumes one system clock; all lines change on its falling edge.
`timescale 1ns/100ps
`default_nettype none

module frame_host_model (
  input  wire logic clk_sys_i,
  output logic      master_clock_o,
  output logic      sync_three_o,
  output logic      slot0_o,
  output logic      slot1_o,
  output logic      frame_sync_o
);
  // ****************************************************************
  // Frame of 40 system cycles, master clock of 10
  // ****************************************************************
  int fcnt = 0;
  int mcnt = 0;
  int scnt = 0;
  initial begin
    {master_clock_o, sync_three_o, slot0_o, slot1_o, frame_sync_o} = '0;
  end
  always @(negedge clk_sys_i) begin
    mcnt = (mcnt == 4) ? 0 : mcnt + 1;
    if (mcnt == 0) master_clock_o = !master_clock_o;
    scnt = (scnt == 12) ? 0 : scnt + 1;
    if (scnt == 0) sync_three_o = !sync_three_o;
    fcnt = (fcnt == 39) ? 0 : fcnt + 1;
    slot0_o = (fcnt == 0);
    slot1_o = (fcnt == 8);
    // Slave frame sync spans a few cycles so the synchroniser sees it
    frame_sync_o = (fcnt < 4);
  end
endmodule // frame_host_model

`default_nettype wire

// File: dv/clkgen_ctrl_regs_checker.sv
// Port-level assertions for the clock generator control registers.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/100ps
`default_nettype none

module clkgen_ctrl_regs_checker (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        power_down_n_i,
  input wire logic        master_clock_in_i,
  input wire logic        sync_input_three_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        slot1_start_i,
  input wire logic        slot1_valid_o,
  input wire logic        gen2_enable_i,
  input wire logic [16:0] gen2_conv_rate_hz_o,
  input wire logic        gen2_phase_step_o,
  input wire logic        gen3_ref_clock_o,
  input wire logic        gen3_reference_select_o,
  input wire logic        gen3_video_lock_o,
  input wire logic        gen3_eight_sevenths_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  property p_rvalid; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read not answered next cycle");
  property p_rdata_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  // Either the plain default or its 8/7 scaling
  property p_pd_rate;
    (!power_down_n_i)[*5] |->
      gen2_conv_rate_hz_o inside {17'h0bb80, 17'h0d649};
  endproperty
  a_pd_rate: assert property (p_pd_rate)
    else $error("rate not at default in power-down");
  property p_off_still; (!gen2_enable_i)[*4] |-> !gen2_phase_step_o;
  endproperty
  a_off_still: assert property (p_off_still)
    else $error("phase step while generator disabled");
  property p_step_pulse; gen2_phase_step_o |=> !gen2_phase_step_o;
  endproperty
  a_step_pulse: assert property (p_step_pulse)
    else $error("phase step longer than one cycle");
  property p_echo; slot1_valid_o |-> $past(slot1_start_i); endproperty
  a_echo: assert property (p_echo)
    else $error("echo outside slot 1");
  property p_vid; gen3_video_lock_o |-> gen3_reference_select_o;
  endproperty
  a_vid: assert property (p_vid)
    else $error("video lock without sync reference");
  property p_x87; gen3_eight_sevenths_o |-> !gen3_reference_select_o;
  endproperty
  a_x87: assert property (p_x87)
    else $error("8/7 active on sync reference");
  property p_ref_sync;
    (gen3_reference_select_o && $stable(sync_input_three_i))[*4] |->
      gen3_ref_clock_o == sync_input_three_i;
  endproperty
  a_ref_sync: assert property (p_ref_sync)
    else $error("reference clock not from sync input");
  property p_ref_xtal;
    (!gen3_reference_select_o && $stable(master_clock_in_i))[*4] |->
      gen3_ref_clock_o == master_clock_in_i;
  endproperty
  a_ref_xtal: assert property (p_ref_xtal)
    else $error("reference clock not from master clock");
endmodule // clkgen_ctrl_regs_checker

`default_nettype wire

// File: dv/clkgen_ctrl_regs_tb.sv
// Self-checking bench for the clock generator control registers.
// Assumes the frame model supplies slots and clock pins.
`timescale 1ns/100ps
`default_nettype none

module clkgen_ctrl_regs_tb;
  import clkgen_ctrl_pkg::*;
  // ****************************************************************
  // Stimulus and hookup
  // ****************************************************************
  logic        clk_sys_i, rstn_i, pd_n, wr, rd, bm, g2ref, g287, gen2_enable;
  logic        mclk, sync_input_three, s0, s1, fsync, rvalid, s1v, step, dir;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, s1d, v;
  logic [16:0] conv;
  wire  [13:0] g3;
  int          fail_count = 0;
  int          checks_done = 0;
  int          steps = 0;

  frame_host_model host (.clk_sys_i(clk_sys_i), .master_clock_o(mclk),
    .sync_three_o(sync_input_three), .slot0_o(s0), .slot1_o(s1),
    .frame_sync_o(fsync));
  clkgen_ctrl_regs uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .power_down_n_i(pd_n), .master_clock_in_i(mclk),
    .sync_input_three_i(sync_input_three), .slave_frame_sync_in_i(fsync),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .bus_master_i(bm), .slot0_start_i(s0), .slot1_start_i(s1),
    .slot1_data_o(s1d), .slot1_valid_o(s1v),
    .gen2_sync_reference_select_i(g2ref), .gen2_eight_sevenths_i(g287),
    .gen2_enable_i(gen2_enable), .gen2_conv_rate_hz_o(conv),
    .gen2_phase_step_o(step), .gen2_phase_direction_o(dir),
    .gen3_ref_clock_o(), .gen3_reference_select_o(g3[13]),
    .gen3_video_lock_o(g3[12]), .gen3_loop_gain_o(g3[11]),
    .gen3_bitclk_plus200_o(g3[10]), .gen3_eight_sevenths_o(g3[9]),
    .gen3_conv_pin_times128_o(g3[8]), .gen3_rate_modifier_o(g3[7:0]));

  initial begin
    clk_sys_i = 0;
    forever #2 clk_sys_i = !clk_sys_i;
  end
  always @(posedge clk_sys_i) if (step === 1'b1) steps++;

  task automatic check(input string nm, input logic [16:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk_sys_i);
    wr = 0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys_i);
    {rd, addr} = {1'b1, a};
    @(negedge clk_sys_i);
    rd = 0;
    check("rvalid", {16'h0, rvalid}, 17'h1);
    d = rdata;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd_reg(a, d);
    check("rdata", {1'b0, d}, {1'b0, e});
  endtask
  task automatic echo_chk(input logic [15:0] e);
    int n;
    for (n = 0; n < 120 && s1v !== 1'b1; n++) @(negedge clk_sys_i);
    check("echo", {1'b0, s1v, s1d}, {2'b01, e});
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  initial begin
    {rstn_i, wr, rd, g2ref, g287, gen2_enable, addr, wdata} = '0;
    {pd_n, bm} = 2'b11;
    repeat (16) @(negedge clk_sys_i);
    rstn_i = 1;
    repeat (4) @(negedge clk_sys_i);
    rd_chk(ADDR_GEN2_SAMPLE_RATE, 16'hbb80);
    rd_chk(ADDR_GEN2_PHASE_SHIFT, 16'h0000);
    rd_chk(ADDR_GEN3_MODE, 16'h0000);
    rd_chk(5'h13, 16'h0000);
    wr_reg(ADDR_GEN2_SAMPLE_RATE, 16'h0fa0);
    rd_chk(ADDR_GEN2_SAMPLE_RATE, 16'h0fa0);
    check("conv", conv, 17'h00fa0);
    g287 = 1;
    repeat (3) @(negedge clk_sys_i);
    check("conv87", conv, 17'h011db);
    g2ref = 1;
    repeat (3) @(negedge clk_sys_i);
    check("convref", conv, 17'h00fa0);
    {g2ref, g287} = 2'b00;
    wr_reg(ADDR_GEN2_SAMPLE_RATE, 16'hd2f0);
    rd_chk(ADDR_GEN2_SAMPLE_RATE, 16'hd2f0);
    wr_reg(ADDR_GEN3_MODE, 16'hfcff);
    echo_chk(16'h0000);
    rd_chk(ADDR_GEN3_MODE, 16'hfcff);
    check("g3", {3'b0, g3}, 17'h03dff);
    wr_reg(ADDR_GEN3_MODE, 16'h0800);
    echo_chk(16'hfcff);
    check("g3", {3'b0, g3}, 17'h00200);
    gen2_enable = 1;
    steps = 0;
    wr_reg(ADDR_GEN2_PHASE_SHIFT, 16'h0105);
    check("dir", {16'h0, dir}, 17'h1);
    repeat (600) @(negedge clk_sys_i);
    check("steps", 17'(steps), 17'd5);
    repeat (200) @(negedge clk_sys_i);
    check("steps", 17'(steps), 17'd5);
    rd_chk(ADDR_GEN2_PHASE_SHIFT, 16'h0100);
    wr_reg(ADDR_GEN2_PHASE_SHIFT, 16'h00c8);
    repeat (200) @(negedge clk_sys_i);
    rd_reg(ADDR_GEN2_PHASE_SHIFT, v);
    check("pend", {16'h0, v < 16'h00c8 && v > 0}, 17'h1);
    wr_reg(ADDR_GEN2_PHASE_SHIFT, 16'h0003);
    repeat (500) @(negedge clk_sys_i);
    rd_chk(ADDR_GEN2_PHASE_SHIFT, 16'h0000);
    wr_reg(ADDR_GEN2_PHASE_SHIFT, 16'h0050);
    gen2_enable = 0;
    repeat (50) @(negedge clk_sys_i);
    rd_chk(ADDR_GEN2_PHASE_SHIFT, 16'h0000);
    wr_reg(ADDR_GEN2_PHASE_SHIFT, 16'h0010);
    repeat (50) @(negedge clk_sys_i);
    rd_chk(ADDR_GEN2_PHASE_SHIFT, 16'h0000);
    {gen2_enable, bm} = 2'b10;
    wr_reg(ADDR_GEN2_PHASE_SHIFT, 16'h00c8);
    // A tick and then a frame sync must both fall inside the wait
    repeat (200) @(negedge clk_sys_i);
    rd_reg(ADDR_GEN2_PHASE_SHIFT, v);
    check("slave", {16'h0, v > 0 && v < 16'h00c8}, 17'h1);
    pd_n = 0;
    repeat (5) @(negedge clk_sys_i);
    wr_reg(ADDR_GEN2_SAMPLE_RATE, 16'h1234);
    rd_chk(ADDR_GEN2_SAMPLE_RATE, 16'hbb80);
    rd_chk(ADDR_GEN2_PHASE_SHIFT, 16'h0000);
    pd_n = 1;
    repeat (4) @(negedge clk_sys_i);
    wr_reg(ADDR_GEN2_SAMPLE_RATE, 16'h1234);
    rd_chk(ADDR_GEN2_SAMPLE_RATE, 16'h1234);
    print_verdict();
  end
endmodule // clkgen_ctrl_regs_tb

bind clkgen_ctrl_regs clkgen_ctrl_regs_checker chk (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .power_down_n_i(power_down_n_i),
  .master_clock_in_i(master_clock_in_i),
  .sync_input_three_i(sync_input_three_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .slot1_start_i(slot1_start_i), .slot1_valid_o(slot1_valid_o),
  .gen2_enable_i(gen2_enable_i), .gen2_conv_rate_hz_o(gen2_conv_rate_hz_o),
  .gen2_phase_step_o(gen2_phase_step_o),
  .gen3_ref_clock_o(gen3_ref_clock_o),
  .gen3_reference_select_o(gen3_reference_select_o),
  .gen3_video_lock_o(gen3_video_lock_o),
  .gen3_eight_sevenths_o(gen3_eight_sevenths_o));

`default_nettype wire
